/* src/crpmc_defs.svh */
// Register indices, field positions, reset values and timing counts
`ifndef CRPMC_DEFS_SVH
`define CRPMC_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define CRPMC_IDX_POWER_CONTROL   8'h87
`define CRPMC_IDX_AUX_CONTROL_ONE 8'ha2
`define CRPMC_IDX_STARTUP_CAUSE   8'ha3
`define CRPMC_IDX_CORE_CONFIG     8'hf1
`define CRPMC_IDX_PRIO_A          8'hf4
`define CRPMC_IDX_PRIO_B          8'hf5
`define CRPMC_IDX_PRIO_C          8'hf6
`define CRPMC_IDX_WATCHDOG_CNT    8'hff

// power_control fields
`define CRPMC_PC_IDLE       0
`define CRPMC_PC_PDOWN      1
`define CRPMC_PC_GF0        2
`define CRPMC_PC_GF1        3
`define CRPMC_PC_WLE        4
`define CRPMC_PC_BAUD       7
// auxiliary_control_one and core_configuration fields
`define CRPMC_AUX_SOFT_RESTART 5
`define CRPMC_CORE_CONFIGURATION_RELOAD_SEL  1
`define CRPMC_CORE_CONFIGURATION_BOOT_TRIG   2

// Start-up cause codes
`define CRPMC_CAUSE_NONE    3'h0
`define CRPMC_CAUSE_SOFT    3'h1
`define CRPMC_CAUSE_WDOG    3'h2
`define CRPMC_CAUSE_EXT     3'h4

// Reset values
`define CRPMC_RST_ZERO      8'h00
`define CRPMC_RST_PORT      8'hff
`define CRPMC_RST_STACK     8'h07
`define CRPMC_RST_PRESCALE  8'h3f
`define CRPMC_RST_SPI_CTL   8'h04

// Timing
`define CRPMC_MACHINE_CLKS  3
`define CRPMC_WLE_MCYCLES   13
`define CRPMC_WLE_CLKS      (`CRPMC_WLE_MCYCLES * `CRPMC_MACHINE_CLKS)
`define CRPMC_RESTART_CLKS  3

// Interrupt sources
`define CRPMC_NUM_IRQ       10

`endif

/* src/crpmc_pkg.sv */
// Types for the reset and power-mode controller
package crpmc_pkg;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_HOLD  = 3'b001,
    ST_BOOT  = 3'b010,
    ST_DELAY = 3'b011
  } crpmc_seq_t;

  typedef struct packed {
    crpmc_seq_t  seq;
    logic [5:0]  delayCnt;
    logic [7:0]  powerControl;
    logic [7:0]  auxControlOne;
    logic [2:0]  startupCauseFlags;
    logic [7:0]  coreConfig;
    logic [7:0]  watchdogCounter;
    logic [23:0] prio;
    logic [5:0]  wleCnt;
    logic        rstaMeta;
    logic        rstaSync;
    logic        wdgMeta;
    logic        wdgSync;
    logic        wdgPrev;
    logic        busAck;
    logic [7:0]  readData;
    logic        bootReload;
    logic        sfrInit;
    logic        coreHalt;
    logic        reloadStrobe;
    logic        strobeOut;
    logic [7:0]  portInit;
    logic [7:0]  stackInit;
    logic [7:0]  prescaleInit;
    logic [7:0]  spiCtlInit;
    logic        winValid;
    logic [3:0]  winIndex;
    logic [1:0]  winLevel;
  } crpmc_state_t;

endpackage

/* src/core_reset_power_mode_ctrl.sv */
// Reset sequencing, start-up cause, power modes and interrupt arbitration
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
`include "crpmc_defs.svh"

module core_reset_power_mode_ctrl (
  input  wire logic        clk,
  input  wire logic        soft_restart,
  input  wire logic [9:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic      [31:0] avsReadData,
  output logic             avsWaitRequest,
  input  wire logic        asyncResetIn,
  input  wire logic        watchdogResetN,
  input  wire logic        watchdogEnabled,
  input  wire logic        bootDone,
  input  wire logic [9:0]  irqPending,
  input  wire logic        extIntWake,
  input  wire logic        cpuProgramStrobe,
  output logic             bootReloadStart,
  output logic             coreHalt,
  output logic             sfrInit,
  output logic             cpuStop,
  output logic             periphStop,
  output logic             portHold,
  output logic             programStoreStrobe,
  output logic             watchdogReload,
  output logic      [7:0]  watchdogReloadValue,
  output logic             baudDouble,
  output logic      [7:0]  portInitValue,
  output logic      [7:0]  stackPointerInit,
  output logic      [7:0]  timerPrescalerInit,
  output logic      [7:0]  spiControlInit,
  output logic             irqWinValid,
  output logic      [3:0]  irqWinIndex,
  output logic      [1:0]  irqWinLevel
);
  import crpmc_pkg::*;

  crpmc_state_t cur_ff;
  crpmc_state_t nxt_cur;

  // Two-bit priority field of one source
  function automatic logic [1:0] prioOf(input logic [23:0] p,
                                        input int          idx);
    prioOf = p[idx*2 +: 2];
  endfunction

  logic        busReq;
  logic        busDo;
  logic        wrLane;
  logic [7:0]  regIdx;
  logic [7:0]  wrByte;
  logic [7:0]  rdByte;
  logic        rstaRise;
  logic        wdgFall;
  logic        softRestart;
  logic        bootTrigSet;
  logic        doInit;
  logic        doBoot;
  logic [2:0]  newCause;
  logic        winV;
  logic [3:0]  winI;
  logic [1:0]  winL;

  assign busReq         = avsRead | avsWrite;
  assign avsWaitRequest = busReq & ~cur_ff.busAck;
  assign busDo          = busReq & cur_ff.busAck;
  assign wrLane         = avsWrite & busDo & avsByteEnable[0];
  assign regIdx         = avsAddress[9:2];
  assign wrByte         = avsWriteData[7:0];
  assign avsReadData    = {24'h000000, cur_ff.readData};

  assign rstaRise    = cur_ff.rstaSync & (cur_ff.seq != ST_HOLD);
  assign wdgFall     = cur_ff.wdgPrev & ~cur_ff.wdgSync;
  assign softRestart = wrLane & (regIdx == `CRPMC_IDX_AUX_CONTROL_ONE) &
                       wrByte[`CRPMC_AUX_SOFT_RESTART];
  assign bootTrigSet = wrLane & (regIdx == `CRPMC_IDX_CORE_CONFIG) &
                       wrByte[`CRPMC_CORE_CONFIGURATION_BOOT_TRIG] &
                       ~cur_ff.coreConfig[`CRPMC_CORE_CONFIGURATION_BOOT_TRIG];

  always_comb begin
    rdByte = 8'h00;
    case (regIdx)
      `CRPMC_IDX_POWER_CONTROL:   rdByte = cur_ff.powerControl;
      `CRPMC_IDX_AUX_CONTROL_ONE: rdByte = cur_ff.auxControlOne;
      `CRPMC_IDX_STARTUP_CAUSE:   rdByte = {5'h00, cur_ff.startupCauseFlags};
      `CRPMC_IDX_CORE_CONFIG:     rdByte = cur_ff.coreConfig;
      `CRPMC_IDX_PRIO_A:          rdByte = cur_ff.prio[7:0];
      `CRPMC_IDX_PRIO_B:          rdByte = cur_ff.prio[15:8];
      `CRPMC_IDX_PRIO_C:          rdByte = cur_ff.prio[23:16];
      `CRPMC_IDX_WATCHDOG_CNT:    rdByte = cur_ff.watchdogCounter;
      default:                    rdByte = 8'h00;
    endcase
  end

  // Highest level wins; on a tie the lower source number wins
  always_comb begin
    winV = 1'b0;
    winI = 4'h0;
    winL = 2'h0;
    for (int i = 0; i < `CRPMC_NUM_IRQ; i++) begin
      if (irqPending[i] && (!winV || prioOf(cur_ff.prio, i) > winL)) begin
        winV = 1'b1;
        winI = 4'(i);
        winL = prioOf(cur_ff.prio, i);
      end
    end
  end

  // Reset causes and their consequences
  always_comb begin
    newCause = `CRPMC_CAUSE_NONE;
    doInit   = 1'b0;
    doBoot   = 1'b0;
    if (rstaRise) begin
      newCause = `CRPMC_CAUSE_EXT;
      doInit   = 1'b1;
    end else if (wdgFall) begin
      newCause = `CRPMC_CAUSE_WDOG;
      doInit   = 1'b1;
      doBoot   = cur_ff.coreConfig[`CRPMC_CORE_CONFIGURATION_RELOAD_SEL];
    end else if (softRestart) begin
      newCause = `CRPMC_CAUSE_SOFT;
      doInit   = 1'b1;
    end else if (bootTrigSet) begin
      doBoot   = 1'b1;
    end
  end

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rstaMeta   = asyncResetIn;
    nxt_cur.rstaSync   = cur_ff.rstaMeta;
    nxt_cur.wdgMeta    = watchdogResetN;
    nxt_cur.wdgSync    = cur_ff.wdgMeta;
    nxt_cur.wdgPrev    = cur_ff.wdgSync;
    nxt_cur.busAck     = busReq & ~cur_ff.busAck;
    nxt_cur.bootReload = 1'b0;
    nxt_cur.sfrInit    = 1'b0;
    nxt_cur.reloadStrobe = 1'b0;
    nxt_cur.winValid   = winV;
    nxt_cur.winIndex   = winI;
    nxt_cur.winLevel   = winL;
    if (busReq && !cur_ff.busAck) begin
      nxt_cur.readData = avsRead ? rdByte : 8'h00;
    end

    // Register writes
    if (wrLane) begin
      case (regIdx)
        `CRPMC_IDX_POWER_CONTROL: begin
          nxt_cur.powerControl[`CRPMC_PC_BAUD] = wrByte[`CRPMC_PC_BAUD];
          nxt_cur.powerControl[`CRPMC_PC_GF1]  = wrByte[`CRPMC_PC_GF1];
          nxt_cur.powerControl[`CRPMC_PC_GF0]  = wrByte[`CRPMC_PC_GF0];
          if (wrByte[`CRPMC_PC_WLE]) begin
            nxt_cur.powerControl[`CRPMC_PC_WLE] = 1'b1;
            nxt_cur.wleCnt = 6'(`CRPMC_WLE_CLKS);
          end
          if (!watchdogEnabled) begin
            if (wrByte[`CRPMC_PC_PDOWN]) begin
              nxt_cur.powerControl[`CRPMC_PC_PDOWN] = 1'b1;
              nxt_cur.powerControl[`CRPMC_PC_IDLE]  = 1'b0;
            end else if (wrByte[`CRPMC_PC_IDLE]) begin
              nxt_cur.powerControl[`CRPMC_PC_IDLE]  = 1'b1;
            end
          end
        end
        `CRPMC_IDX_AUX_CONTROL_ONE: nxt_cur.auxControlOne = wrByte;
        `CRPMC_IDX_CORE_CONFIG:     nxt_cur.coreConfig    = wrByte;
        `CRPMC_IDX_PRIO_A:          nxt_cur.prio[7:0]     = wrByte;
        `CRPMC_IDX_PRIO_B:          nxt_cur.prio[15:8]    = wrByte;
        `CRPMC_IDX_PRIO_C:          nxt_cur.prio[23:16]   = wrByte;
        `CRPMC_IDX_WATCHDOG_CNT: begin
          // Reload attempts without the load enable are dropped silently
          if (cur_ff.powerControl[`CRPMC_PC_WLE]) begin
            nxt_cur.watchdogCounter = wrByte;
            nxt_cur.reloadStrobe    = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Load enable window; a fresh write above restarts the count
    if (cur_ff.powerControl[`CRPMC_PC_WLE] && !(wrLane &&
        regIdx == `CRPMC_IDX_POWER_CONTROL && wrByte[`CRPMC_PC_WLE])) begin
      if (cur_ff.wleCnt <= 6'h01) begin
        nxt_cur.powerControl[`CRPMC_PC_WLE] = 1'b0;
        nxt_cur.wleCnt = 6'h00;
      end else begin
        nxt_cur.wleCnt = cur_ff.wleCnt - 6'h01;
      end
    end

    // Wake-ups
    if (cur_ff.powerControl[`CRPMC_PC_IDLE] && (|irqPending)) begin
      nxt_cur.powerControl[`CRPMC_PC_IDLE] = 1'b0;
    end
    if (cur_ff.powerControl[`CRPMC_PC_PDOWN] && extIntWake) begin
      nxt_cur.powerControl[`CRPMC_PC_PDOWN] = 1'b0;
    end

    // Reinitialisation loads the new cause into the start-up flags and never reaches RAM
    if (doInit) begin
      nxt_cur.startupCauseFlags = newCause;
      nxt_cur.powerControl    = `CRPMC_RST_ZERO;
      nxt_cur.auxControlOne   = `CRPMC_RST_ZERO;
      nxt_cur.coreConfig      = `CRPMC_RST_ZERO;
      nxt_cur.watchdogCounter = `CRPMC_RST_ZERO;
      nxt_cur.prio            = 24'h000000;
      nxt_cur.wleCnt          = 6'h00;
      nxt_cur.sfrInit         = 1'b1;
      nxt_cur.portInit        = `CRPMC_RST_PORT;
      nxt_cur.stackInit       = `CRPMC_RST_STACK;
      nxt_cur.prescaleInit    = `CRPMC_RST_PRESCALE;
      nxt_cur.spiCtlInit      = `CRPMC_RST_SPI_CTL;
      nxt_cur.coreHalt        = 1'b1;
    end

    // Sequencer
    case (cur_ff.seq)
      ST_RUN: begin
        if (rstaRise) begin
          nxt_cur.seq = ST_HOLD;
        end else if (doBoot) begin
          nxt_cur.seq        = ST_BOOT;
          nxt_cur.coreHalt   = 1'b1;
          nxt_cur.bootReload = 1'b1;
        end else if (doInit) begin
          nxt_cur.seq      = ST_DELAY;
          nxt_cur.delayCnt = 6'(`CRPMC_RESTART_CLKS);
        end
      end
      ST_HOLD: begin
        nxt_cur.coreHalt = 1'b1;
        if (!cur_ff.rstaSync) begin
          nxt_cur.seq        = ST_BOOT;
          nxt_cur.bootReload = 1'b1;
        end
      end
      ST_BOOT: begin
        if (rstaRise) begin
          nxt_cur.seq = ST_HOLD;
        end else if (bootDone) begin
          nxt_cur.seq      = ST_DELAY;
          nxt_cur.delayCnt = 6'(`CRPMC_RESTART_CLKS);
        end
      end
      ST_DELAY: begin
        if (rstaRise) begin
          nxt_cur.seq = ST_HOLD;
        end else if (cur_ff.delayCnt <= 6'h01) begin
          nxt_cur.seq      = ST_RUN;
          nxt_cur.coreHalt = 1'b0;
          nxt_cur.delayCnt = 6'h00;
        end else begin
          nxt_cur.delayCnt = cur_ff.delayCnt - 6'h01;
        end
      end
      default: begin
        nxt_cur.seq = ST_RUN;
      end
    endcase

    // Program strobe override in the saving modes
    if (nxt_cur.powerControl[`CRPMC_PC_PDOWN]) begin
      nxt_cur.strobeOut = 1'b0;
    end else if (nxt_cur.powerControl[`CRPMC_PC_IDLE]) begin
      nxt_cur.strobeOut = 1'b1;
    end else begin
      nxt_cur.strobeOut = cpuProgramStrobe;
    end
  end

  always_ff @(posedge clk) begin
    if (soft_restart) begin
      cur_ff <= '0;
      cur_ff.seq          <= ST_RUN;
      cur_ff.wdgMeta      <= 1'b1;
      cur_ff.wdgSync      <= 1'b1;
      cur_ff.wdgPrev      <= 1'b1;
      cur_ff.strobeOut    <= 1'b1;
      cur_ff.portInit     <= `CRPMC_RST_PORT;
      cur_ff.stackInit    <= `CRPMC_RST_STACK;
      cur_ff.prescaleInit <= `CRPMC_RST_PRESCALE;
      cur_ff.spiCtlInit   <= `CRPMC_RST_SPI_CTL;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign bootReloadStart    = cur_ff.bootReload;
  assign coreHalt           = cur_ff.coreHalt;
  assign sfrInit            = cur_ff.sfrInit;
  // Idle stops only the CPU; power-down also stops the peripherals
  assign cpuStop            = cur_ff.coreHalt |
                              cur_ff.powerControl[`CRPMC_PC_IDLE] |
                              cur_ff.powerControl[`CRPMC_PC_PDOWN];
  assign periphStop         = cur_ff.powerControl[`CRPMC_PC_PDOWN];
  assign portHold           = cur_ff.powerControl[`CRPMC_PC_IDLE];
  assign programStoreStrobe = cur_ff.strobeOut;
  assign watchdogReload     = cur_ff.reloadStrobe;
  assign watchdogReloadValue = cur_ff.watchdogCounter;
  assign baudDouble         = cur_ff.powerControl[`CRPMC_PC_BAUD];
  assign portInitValue      = cur_ff.portInit;
  assign stackPointerInit   = cur_ff.stackInit;
  assign timerPrescalerInit = cur_ff.prescaleInit;
  assign spiControlInit     = cur_ff.spiCtlInit;
  assign irqWinValid        = cur_ff.winValid;
  assign irqWinIndex        = cur_ff.winIndex;
  assign irqWinLevel        = cur_ff.winLevel;

endmodule

/* verif/crpmc_chk.sv */
// Port-level assertions for the reset and power-mode controller
`timescale 1ns/100ps
module crpmc_chk (
  input wire logic        clk,
  input wire logic        soft_restart,
  input wire logic [9:0]  avsAddress,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0]  avsByteEnable,
  input wire logic        avsWaitRequest,
  input wire logic        asyncResetIn,
  input wire logic        watchdogEnabled,
  input wire logic [9:0]  irqPending,
  input wire logic        extIntWake,
  input wire logic        bootReloadStart,
  input wire logic        coreHalt,
  input wire logic        sfrInit,
  input wire logic        cpuStop,
  input wire logic        periphStop,
  input wire logic        portHold,
  input wire logic        programStoreStrobe,
  input wire logic        watchdogReload,
  input wire logic [7:0]  portInitValue,
  input wire logic [7:0]  stackPointerInit,
  input wire logic [7:0]  timerPrescalerInit,
  input wire logic [7:0]  spiControlInit,
  input wire logic        irqWinValid,
  input wire logic [3:0]  irqWinIndex
);
  logic       accept;
  logic       pcWr;
  logic       wdcWr;
  logic [9:0] pendQ;
  assign accept = avsWrite && !avsWaitRequest && avsByteEnable[0];
  assign pcWr   = accept && avsAddress[9:2] == 8'h87;
  assign wdcWr  = accept && avsAddress[9:2] == 8'hff;
  // Winner is one clock late, so compare against last cycle's requests
  always_ff @(posedge clk) pendQ <= irqPending;
  default clocking @(posedge clk); endclocking
  default disable iff (soft_restart);
  a_halt_on_ext: assert property (asyncResetIn [*4] |=> coreHalt)
    else $error("core not held during external reset");
  a_idle_hold: assert property (portHold && $past(portHold) |->
    programStoreStrobe && cpuStop) else $error("idle strobe or stop wrong");
  a_pd_strobe: assert property (periphStop && $past(periphStop) |->
    !programStoreStrobe && cpuStop) else $error("power-down strobe wrong");
  a_both_pd: assert property (pcWr && avsWriteData[1:0] == 2'h3 &&
    !watchdogEnabled && !extIntWake && !asyncResetIn |=>
    periphStop && !portHold) else $error("power-down did not win");
  a_wdog_blocks: assert property (pcWr && watchdogEnabled &&
    !portHold && !periphStop |=> !portHold && !periphStop)
    else $error("saving mode entered with watchdog on");
  a_idle_irq: assert property (portHold && |irqPending |=> !portHold)
    else $error("idle not left on interrupt");
  a_pd_wake: assert property (periphStop && extIntWake && !avsWrite
    |=> !periphStop) else $error("power-down not left on wake");
  a_reload_cause: assert property (watchdogReload |-> $past(wdcWr))
    else $error("watchdog reload without counter write");
  a_init_values: assert property (sfrInit |-> portInitValue == 8'hff &&
    stackPointerInit == 8'h07 && timerPrescalerInit == 8'h3f &&
    spiControlInit == 8'h04) else $error("reset values wrong");
  a_win_pending: assert property (irqWinValid |-> pendQ[irqWinIndex])
    else $error("interrupt winner not pending");
  cover property (periphStop && extIntWake);
  cover property (portHold && |irqPending);
  cover property (bootReloadStart);
endmodule
bind core_reset_power_mode_ctrl crpmc_chk crpmc_chk_inst (
  .clk, .soft_restart, .avsAddress, .avsWrite, .avsWriteData, .avsByteEnable,
  .avsWaitRequest, .asyncResetIn, .watchdogEnabled, .irqPending,
  .extIntWake, .bootReloadStart, .coreHalt, .sfrInit, .cpuStop,
  .periphStop, .portHold, .programStoreStrobe, .watchdogReload,
  .portInitValue, .stackPointerInit, .timerPrescalerInit,
  .spiControlInit, .irqWinValid, .irqWinIndex);

/* verif/crpmc_partner.sv */
// Behavioural CPU side: boot loader, interrupt lines and fetch strobe
`timescale 1ns/100ps
module crpmc_partner (
  input  wire logic       clk,
  input  wire logic       bootReloadStart,
  input  wire logic       slow,
  input  wire logic [9:0] irqReq,
  input  wire logic       wakeReq,
  output logic            bootDone,
  output logic      [9:0] irqPending,
  output logic            extIntWake,
  output logic            cpuProgramStrobe
);
  int cnt = 0;
  initial begin
    bootDone = 1'h0;
    cpuProgramStrobe = 1'h1;
  end
  // Slow load keeps the halt window wide enough to observe
  always @(posedge clk) begin
    if (bootReloadStart)
      cnt <= slow ? 20 : 2;
    else if (cnt != 0)
      cnt <= cnt - 1;
    bootDone <= cnt == 1 && !bootReloadStart;
    cpuProgramStrobe <= ~cpuProgramStrobe;
  end
  assign irqPending = irqReq;
  assign extIntWake = wakeReq;
endmodule

/* verif/test_core_reset_power_mode_ctrl.sv */
// Self-checking bench for the reset and power-mode controller
`timescale 1ns/100ps
module test_core_reset_power_mode_ctrl;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] d;
    logic       be;
    logic [7:0] q;
  } crpmc_row_t;
  logic        clk = 1'h0, soft_restart = 1'h1, avsRead = 1'h0, avsWrite = 1'h0;
  logic [9:0]  avsAddress = '0, irqReq = '0, irqPending;
  logic [31:0] avsWriteData = '0, avsReadData, q;
  logic [3:0]  avsByteEnable = '0, irqWinIndex;
  logic [7:0]  watchdogReloadValue, portInitValue, stackPointerInit;
  logic [7:0]  timerPrescalerInit, spiControlInit;
  logic [1:0]  irqWinLevel;
  logic        asyncResetIn = 1'h0, watchdogResetN = 1'h1;
  logic        watchdogEnabled = 1'h0, slow = 1'h0, wakeReq = 1'h0;
  logic        bootDone, extIntWake, cpuProgramStrobe, avsWaitRequest;
  logic        bootReloadStart, coreHalt, cpuStop, periphStop, portHold;
  logic        programStoreStrobe, baudDouble, irqWinValid;
  int          errors = 0, num_checks = 0, cycles = 0, bootCnt = 0;
  int          haltCnt = 0;
  logic [7:0]  regs [5] = '{8'h87, 8'ha2, 8'hf1, 8'hff, 8'ha3};
  crpmc_row_t  rows [8] = '{
    '{8'h87, 8'h8c, 1'h1, 8'h8c}, '{8'h87, 8'h00, 1'h0, 8'h8c},
    '{8'hf4, 8'he4, 1'h1, 8'he4}, '{8'hf5, 8'h1b, 1'h1, 8'h1b},
    '{8'hf6, 8'h0b, 1'h1, 8'h0b}, '{8'ha3, 8'h07, 1'h1, 8'h00},
    '{8'h10, 8'h55, 1'h1, 8'h00}, '{8'hff, 8'h5a, 1'h1, 8'h00}};
  core_reset_power_mode_ctrl core_reset_power_mode_ctrl_inst (
    .clk, .soft_restart, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable, .avsReadData, .avsWaitRequest, .asyncResetIn,
    .watchdogResetN, .watchdogEnabled, .bootDone, .irqPending,
    .extIntWake, .cpuProgramStrobe, .bootReloadStart, .coreHalt,
    .sfrInit(), .cpuStop, .periphStop, .portHold, .programStoreStrobe,
    .watchdogReload(), .watchdogReloadValue, .baudDouble,
    .portInitValue, .stackPointerInit, .timerPrescalerInit,
    .spiControlInit, .irqWinValid, .irqWinIndex, .irqWinLevel);
  crpmc_partner crpmc_partner_inst (.clk, .bootReloadStart, .slow,
    .irqReq, .wakeReq, .bootDone, .irqPending, .extIntWake,
    .cpuProgramStrobe);
  always #20 clk = ~clk;
  always @(posedge bootReloadStart) bootCnt++;
  always @(posedge coreHalt) haltCnt++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done;
    end
  end
  task automatic test_done;
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until the rising edge that sees waitrequest low; read
  // data is taken at that edge, and one idle edge separates requests
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, input logic be);
    avsAddress <= {idx, 2'h0};
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= {24'h0, d};
    avsByteEnable <= {3'h0, be};
    do @(posedge clk); while (avsWaitRequest !== 1'h0);
    q = avsReadData;
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'h1, idx, d, 1'h1);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(1'h0, idx, 8'h00, 1'h1);
    chk(q, {24'h0, e});
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
    while (coreHalt !== 1'h0) @(posedge clk);
  endtask
  task automatic wdgPulse;
    watchdogResetN <= 1'h0;
    repeat (4) @(posedge clk);
    watchdogResetN <= 1'h1;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    soft_restart <= 1'h0;
    @(posedge clk);
    foreach (regs[i]) rd(regs[i], 8'h00);
    chk({portInitValue, stackPointerInit, timerPrescalerInit,
         spiControlInit}, 32'hff073f04);
    foreach (rows[i]) begin
      bus(1'h1, rows[i].idx, rows[i].d, rows[i].be);
      rd(rows[i].idx, rows[i].q);
    end
    chk(baudDouble, 1'h1);
    watchdogEnabled <= 1'h1;
    wr(8'h87, 8'h03);
    rd(8'h87, 8'h00);
    watchdogEnabled <= 1'h0;
    wr(8'h87, 8'h01);
    repeat (2) @(posedge clk);
    chk({portHold, cpuStop, periphStop, programStoreStrobe}, 4'hd);
    irqReq <= 10'h00a;
    repeat (3) @(posedge clk);
    chk({portHold, irqWinValid, irqWinIndex, irqWinLevel}, 8'h4f);
    irqReq <= 10'h000;
    wr(8'h87, 8'h03);
    repeat (2) @(posedge clk);
    chk({portHold, cpuStop, periphStop, programStoreStrobe}, 4'h6);
    wakeReq <= 1'h1;
    repeat (3) @(posedge clk);
    chk({cpuStop, periphStop}, 2'h0);
    wakeReq <= 1'h0;
    wr(8'h87, 8'h10);
    wr(8'hff, 8'h77);
    chk(watchdogReloadValue, 8'h77);
    rd(8'h87, 8'h10);
    repeat (40) @(posedge clk);
    rd(8'h87, 8'h00);
    wr(8'hff, 8'h11);
    rd(8'hff, 8'h77);
    wr(8'h87, 8'h04);
    wr(8'ha2, 8'h20);
    settle;
    rd(8'h87, 8'h00);
    rd(8'ha3, 8'h01);
    chk(bootCnt, 0);
    wdgPulse;
    settle;
    rd(8'ha3, 8'h02);
    chk({bootCnt[15:0], haltCnt[15:0]}, {16'd0, 16'd2});
    slow <= 1'h1;
    wr(8'hf1, 8'h02);
    wdgPulse;
    repeat (15) @(posedge clk);
    chk(coreHalt, 1'h1);
    settle;
    chk(bootCnt, 1);
    slow <= 1'h0;
    wr(8'hf1, 8'h04);
    settle;
    chk(bootCnt, 2);
    rd(8'ha3, 8'h02);
    wr(8'h87, 8'h01);
    asyncResetIn <= 1'h1;
    watchdogResetN <= 1'h0;
    repeat (6) @(posedge clk);
    chk(coreHalt, 1'h1);
    asyncResetIn <= 1'h0;
    watchdogResetN <= 1'h1;
    settle;
    chk({portHold, cpuStop, bootCnt[29:0]}, {2'h0, 30'd3});
    rd(8'ha3, 8'h04);
    test_done;
  end
endmodule
